/* File: design/mahp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Address valid before strobe falls
// - Same lines carry address then data
// - Write data held through strobe end
// - Chip select held through strobe
module mahp_host
	import mahp_pkg::*;
#(
	parameter int BUS_W = MAHP_BUS_W
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// User command port
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_sel,
	input wire logic i_req_skip_addr,
	input wire logic [BUS_W-1:0] i_req_addr,
	input wire logic [BUS_W-1:0] i_req_wdata,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [BUS_W-1:0] o_rsp_rdata,
	// Multiplexed bus pins
	input wire logic [BUS_W-1:0] i_muxed_bus,
	output logic [BUS_W-1:0] o_muxed_bus,
	output logic o_muxed_bus_oe_n,
	output logic o_ale,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n
);
	// Sequencer state and phase counter
	mahp_state_type state_q;
	logic [7:0] cnt_q;
	// Latched request
	logic wr_q;
	logic sel_q;
	logic [BUS_W-1:0] addr_q;
	logic [BUS_W-1:0] wdata_q;
	// Bus input synchroniser
	logic [BUS_W-1:0] bus_s1_q;
	logic [BUS_W-1:0] bus_s2_q;
	// Phase end flag
	logic last;

	// Phase ends when the counter reaches zero
	assign last = (cnt_q == 8'h00);
	// Ready only when idle
	assign o_req_ready = (state_q == MAHP_IDLE);

	// Count helper for phase lengths
	function automatic logic [7:0] mahp_len(input int n);
		return 8'(n - 1);
	endfunction

	// Two-stage synchroniser on the pins
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			bus_s1_q <= '0;
			bus_s2_q <= '0;
		end else begin
			bus_s1_q <= i_muxed_bus;
			bus_s2_q <= bus_s1_q;
		end
	end

	// Request capture
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wr_q <= 1'b0;
			sel_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (i_req_valid && o_req_ready) begin
			wr_q <= i_req_write;
			sel_q <= i_req_sel;
			addr_q <= i_req_addr;
			wdata_q <= i_req_wdata;
		end
	end

	// Sequencer: address phase, strobe phase, recovery
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_q <= MAHP_IDLE;
			cnt_q <= 8'h00;
		end else begin
			unique case (state_q)
				MAHP_IDLE: begin
					if (i_req_valid) begin
						// Reuse of last address skips address phase
						if (i_req_skip_addr && i_req_sel) begin
							state_q <= MAHP_STROBE;
							cnt_q <= mahp_len(MAHP_STROBE_CYC);
						end else begin
							state_q <= MAHP_ADDR;
							cnt_q <= mahp_len(MAHP_ADDR_SETUP_CYC);
						end
					end
				end
				MAHP_ADDR: begin
					// Address set up before strobe rises
					if (last) begin
						state_q <= MAHP_ALE;
						cnt_q <= mahp_len(MAHP_ALE_HIGH_CYC);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				MAHP_ALE: begin
					if (last) begin
						state_q <= MAHP_HOLD;
						cnt_q <= mahp_len(MAHP_ALE_HOLD_CYC);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				MAHP_HOLD: begin
					// Address held past strobe fall
					if (!last) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (sel_q) begin
						state_q <= MAHP_STROBE;
						cnt_q <= mahp_len(MAHP_STROBE_CYC);
					end else begin
						// Deselected cycle only latches address
						state_q <= MAHP_RECOVER;
						cnt_q <= mahp_len(MAHP_RECOVER_CYC);
					end
				end
				MAHP_STROBE: begin
					if (last) begin
						state_q <= MAHP_RECOVER;
						cnt_q <= mahp_len(MAHP_RECOVER_CYC);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				MAHP_RECOVER: begin
					// Gap lets device release bus
					if (last) begin
						state_q <= MAHP_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
			endcase
		end
	end

	// Pin drive, all from flip-flops
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_muxed_bus <= '0;
			o_muxed_bus_oe_n <= 1'b1;
			o_ale <= 1'b0;
			o_cs_n <= 1'b1;
			o_rd_n <= 1'b1;
			o_wr_n <= 1'b1;
		end else begin
			// Defaults: strobes idle, bus released
			o_ale <= 1'b0;
			o_rd_n <= 1'b1;
			o_wr_n <= 1'b1;
			o_cs_n <= 1'b1;
			o_muxed_bus_oe_n <= 1'b1;
			unique case (state_q)
				MAHP_IDLE: begin
					o_muxed_bus <= o_muxed_bus;
				end
				MAHP_ADDR, MAHP_ALE, MAHP_HOLD: begin
					// Address on shared lines
					o_muxed_bus <= addr_q;
					o_muxed_bus_oe_n <= 1'b0;
					// Strobe high only in its own phase, after set-up
					o_ale <= (state_q == MAHP_ALE);
					o_cs_n <= !sel_q;
				end
				MAHP_STROBE: begin
					// Chip select across strobe
					o_cs_n <= 1'b0;
					o_wr_n <= !(wr_q && !last);
					o_rd_n <= !(!wr_q && !last);
					// Write data held through strobe
					o_muxed_bus <= wdata_q;
					o_muxed_bus_oe_n <= !wr_q;
				end
				MAHP_RECOVER: begin
					o_muxed_bus <= o_muxed_bus;
				end
			endcase
		end
	end

	// Read byte sampled at strobe end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rsp_valid <= 1'b0;
			o_rsp_rdata <= '0;
		end else begin
			o_rsp_valid <= 1'b0;
			if (state_q == MAHP_RECOVER && cnt_q == mahp_len(MAHP_RECOVER_CYC)
				&& sel_q && !wr_q && !o_req_ready) begin
				o_rsp_rdata <= bus_s2_q;
				o_rsp_valid <= 1'b1;
			end
		end
	end
endmodule // mahp_host
`default_nettype wire

/* File: design/mahp_pkg.sv */
package mahp_pkg;
	// Bus width of the multiplexed address/data lines
	localparam int MAHP_BUS_W = 8;
	// Phase lengths in ns, printed figures of our own choosing
	localparam int MAHP_T_ADDR_SETUP_NS = 40;
	localparam int MAHP_T_ALE_HIGH_NS = 60;
	localparam int MAHP_T_ALE_HOLD_NS = 20;
	localparam int MAHP_T_STROBE_NS = 160;
	localparam int MAHP_T_RECOVER_NS = 40;
	// Clock period in ns
	localparam int MAHP_CLK_NS = 20;
	// Least times round up to whole cycles, never below one
	function automatic int mahp_cyc(input int t_ns);
		int c;
		c = (t_ns + MAHP_CLK_NS - 1) / MAHP_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int MAHP_ADDR_SETUP_CYC = mahp_cyc(MAHP_T_ADDR_SETUP_NS);
	localparam int MAHP_ALE_HIGH_CYC = mahp_cyc(MAHP_T_ALE_HIGH_NS);
	localparam int MAHP_ALE_HOLD_CYC = mahp_cyc(MAHP_T_ALE_HOLD_NS);
	localparam int MAHP_STROBE_CYC = mahp_cyc(MAHP_T_STROBE_NS);
	localparam int MAHP_RECOVER_CYC = mahp_cyc(MAHP_T_RECOVER_NS);
	// Sequencer states
	typedef enum logic [2:0] {
		MAHP_IDLE,
		MAHP_ADDR,
		MAHP_ALE,
		MAHP_HOLD,
		MAHP_STROBE,
		MAHP_RECOVER
	} mahp_state_type;
endpackage : mahp_pkg

/* File: sim/mahp_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mahp_dev_model #(
	parameter int DLY = 0
) (
	// Host side pins
	input wire logic i_ale,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_bus,
	// Read drivers
	output logic o_drv_en,
	output logic [7:0] o_drv
);
	logic [7:0] mem [256];
	logic [7:0] addr_q;
	// Latch on strobe fall, selected or not
	always @(negedge i_ale) addr_q <= i_bus;
	// Store only while a selected write is low
	always @(i_wr_n, i_cs_n, i_bus) begin
		if (!i_wr_n && !i_cs_n) mem[addr_q] = i_bus;
	end
	// Read strobe enables the drivers, late
	assign #(DLY) o_drv_en = !i_rd_n && !i_cs_n;
	assign o_drv = mem[addr_q];
endmodule // mahp_dev_model
`default_nettype wire

/* File: sim/mahp_host_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module mahp_host_checker #(
	parameter int BUS_W = 8
) (
	// Watched pins
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic [BUS_W-1:0] o_muxed_bus,
	input wire logic o_muxed_bus_oe_n,
	input wire logic o_ale,
	input wire logic o_cs_n,
	input wire logic o_rd_n,
	input wire logic o_wr_n
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// Address driven and steady to the strobe fall
	addr_held_a: assert property (
		o_ale |=> !o_muxed_bus_oe_n && $stable(o_muxed_bus))
		else $error("address moved under strobe");
	// Host lets go of the lines while reading
	bus_freed_a: assert property (
		!o_rd_n |-> o_muxed_bus_oe_n)
		else $error("host drives during read");
	// Write data steady through the strobe
	wdata_held_a: assert property (
		!o_wr_n && $past(!o_wr_n) |-> !o_muxed_bus_oe_n && $stable(o_muxed_bus))
		else $error("write data moved");
	// Select held while any strobe is low
	sel_held_a: assert property (
		!o_rd_n || !o_wr_n |-> !o_cs_n)
		else $error("select dropped in strobe");
	// Main traffic kinds
	cover property (!o_rd_n && !o_cs_n);
	cover property (!o_wr_n && !o_cs_n);
	cover property (o_ale && o_cs_n);
endmodule // mahp_host_checker
bind mahp_host mahp_host_checker #(.BUS_W(BUS_W)) chk_u (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .o_muxed_bus(o_muxed_bus),
	.o_muxed_bus_oe_n(o_muxed_bus_oe_n), .o_ale(o_ale), .o_cs_n(o_cs_n),
	.o_rd_n(o_rd_n), .o_wr_n(o_wr_n));
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'h0, srst = 1'h1, vld = 1'h0, wr = 1'h0, sel = 1'h0;
	logic skip = 1'h0;
	logic rdy, rsp, oe_n, ale, cs_n, rd_n, wr_n, den;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, hout, dout, bus;
	logic [7:0] idle_q = 8'h5A;
	int errors = 0, checks = 0;
	// Released lines show a moving pattern
	always @(posedge clk) idle_q <= ~idle_q;
	assign bus = !oe_n ? hout : den ? dout : idle_q;
	initial begin
		forever #10 clk = ~clk;
	end
	mahp_host dut_u (.i_clk_sys(clk), .i_srst(srst), .i_req_valid(vld),
		.i_req_write(wr), .i_req_sel(sel), .i_req_skip_addr(skip),
		.i_req_addr(addr), .i_req_wdata(wd), .o_req_ready(rdy),
		.o_rsp_valid(rsp), .o_rsp_rdata(rdata), .i_muxed_bus(bus),
		.o_muxed_bus(hout), .o_muxed_bus_oe_n(oe_n), .o_ale(ale),
		.o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n));
	mahp_dev_model #(.DLY(30)) dev_u (.i_ale(ale), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_bus(bus), .o_drv_en(den),
		.o_drv(dout));
	task automatic print_verdict;
		if (errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One request, then wait for idle
	task automatic op(input logic w, s, k, input logic [7:0] a, d,
		output logic got, output logic [7:0] q);
		int n;
		got = 1'b0;
		q = 8'h00;
		@(posedge clk);
		vld <= 1'b1; wr <= w; sel <= s; skip <= k; addr <= a; wd <= d;
		@(posedge clk);
		vld <= 1'b0;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			if (rsp === 1'b1) begin
				got = 1'b1;
				q = rdata;
			end
			if (rdy === 1'b1) break;
		end
		if (n == 60) begin
			errors++;
			print_verdict();
		end
	endtask
	// Writes then reads, clock and memory places
	task automatic t_rw;
		logic g;
		logic [7:0] q;
		logic [7:0] e;
		logic [7:0] a [4] = '{8'h00, 8'h0E, 8'h40, 8'hFF};
		for (int i = 0; i < 4; i++) begin
			op(1'h1, 1'h1, 1'h0, a[i], a[i] ^ 8'h3C, g, q);
			checks++;
			if (g !== 1'h0) begin
				errors++;
				$display("MISMATCH %0t response after write", $time);
			end
		end
		for (int i = 0; i < 4; i++) begin
			e = a[i] ^ 8'h3C;
			op(1'h0, 1'h1, 1'h0, a[i], 8'h00, g, q);
			checks++;
			if (g !== 1'h1) begin
				errors++;
				$display("MISMATCH %0t no read response", $time);
			end
			checks++;
			if (q !== e) begin
				errors++;
				$display("MISMATCH %0t read got %h exp %h", $time, q, e);
			end
		end
	endtask
	// Deselected cycles latch but move nothing
	task automatic t_desel;
		logic g;
		logic [7:0] q;
		op(1'h1, 1'h0, 1'h0, 8'h40, 8'h99, g, q);
		checks++;
		if (g !== 1'h0) begin
			errors++;
			$display("MISMATCH %0t response to deselected write", $time);
		end
		op(1'h0, 1'h0, 1'h0, 8'hFF, 8'h00, g, q);
		checks++;
		if (g !== 1'h0) begin
			errors++;
			$display("MISMATCH %0t response to deselected read", $time);
		end
		op(1'h0, 1'h1, 1'h1, 8'h00, 8'h00, g, q);
		checks++;
		if (q !== 8'hC3) begin
			errors++;
			$display("MISMATCH %0t reused address got %h", $time, q);
		end
		op(1'h0, 1'h1, 1'h0, 8'h40, 8'h00, g, q);
		checks++;
		if (q !== 8'h7C) begin
			errors++;
			$display("MISMATCH %0t deselected write landed", $time);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_rw();
		t_desel();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
